// ==== hw/mih_pkg.sv ====
// Constants and types shared by the instruction hook and capture logic.
package mih_pkg;

    // Instruction decode constants (octal encodings).
    localparam logic [8:0]  MFP_OPC      = 9'h035;  // Bits 14:6 of 0065xx.
    localparam logic [8:0]  MTP_OPC      = 9'h036;  // Bits 14:6 of 0066xx.
    localparam logic [15:0] RESET_OPC    = 16'h0005;
    localparam logic [15:0] NOP_OPC      = 16'h00a0;
    localparam logic [3:0]  MOV_OPC      = 4'h1;
    localparam logic [5:0]  PUSH_SP_FLD  = 6'h26;   // Operand -(SP).
    localparam logic [5:0]  POP_SP_FLD   = 6'h16;   // Operand (SP)+.
    localparam logic [2:0]  SP_REG       = 3'h6;
    localparam logic [2:0]  MODE_ZERO    = 3'h0;

    // Field positions.
    localparam int OPC_HI   = 14;
    localparam int OPC_LO   = 6;
    localparam int OPD_HI   = 5;
    localparam int MODE_LO  = 3;
    localparam int REG_HI   = 2;
    localparam int CUR_HI   = 15;
    localparam int CUR_LO   = 14;
    localparam int PRV_HI   = 13;
    localparam int PRV_LO   = 12;
    localparam int VBA_PAGE = 5;
    localparam int VBA_SR   = 2;

    // Mode codes in the status word.
    localparam logic [1:0] MODE_KERNEL = 2'h0;
    localparam logic [1:0] MODE_USER   = 2'h3;

    // Reset values.
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [17:0] ADDR_RST = 18'h00000;
    localparam logic [1:0]  EXT_RST  = 2'h0;

    // Stack selection outputs towards the register file.
    typedef struct packed {
        logic src_hook;
        logic dst_hook;
        logic move_from_src_mode0_n;
    } mih_hook_t;

    // Console lamp drives, all active low.
    typedef struct packed {
        logic relocation_on_n;
        logic user_mode_lamp_n;
        logic console_addr_lamp17_n;
        logic console_addr_lamp16_n;
    } mih_lamps_t;

endpackage

// ==== hw/mih_top.sv ====
// Instruction hook, fetch address capture, read mux and upper address logic.
//
// Behaviour
// - Recognise move-to/from-previous instructions in fetched word.
// - Jam a plain move word onto read data.
// - Decode instruction bits 14:6 plus two flags.
// - Flag detection, processor recycles and refetches.
// - User-mode reset becomes a no-operation.
// - Capture virtual address on instruction clock fall.
// - Hold captured address while abort is asserted.
// - Read mux picks one of four registers.
// - Console extension loads switches in console loop.
// - Console mode routes extension to upper address.
// - Peripheral page sets upper address bits outside console.
// - Status bits 15:14 current, 13:12 previous mode.
// - Move-from stack pointer mode zero avoids predecrement.
// - Hook signals choose user or kernel stack.
// - User mode inhibits mode field loads on returns.
// - Sequencing bits select mode for fault logic.
// - Sequencing bit gates relocation of each access.
// - Drive 18-bit address from relocation, or from upper bits and virtual address.
// - Virtual lamp follows relocation enable.
// - User lamp lit when status bit 15 set.
// - Console address lamps follow extension register.
// - Abort is the OR of all fault flags.
`timescale 1ns/1ps

module mih_top
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    // Processor fetch side.
    input  wire logic              instr_reg_clock_i,
    input  wire logic [15:0]       instruction_register_i,
    input  wire logic [15:0]       vba_i,
    input  wire logic [15:0]       processor_status_word_i,
    input  wire logic              privileged_instr_n_i,
    input  wire logic              implicit_ps_load_i,
    input  wire logic              user_stack_ref_i,
    // Sequencing store bits.
    input  wire logic              relocation_gate_bit_i,
    input  wire logic [1:0]        mode_select_bits_i,
    // Relocation and fault side.
    input  wire logic              relocate_enable_i,
    input  wire logic [17:0]       relocated_addr_i,
    input  wire logic [3:0]        fault_flags_i,
    // Internal register read.
    input  wire logic              read_mux_enable_n_i,
    input  wire logic              page_reg_select_i,
    input  wire logic [15:0]       page_base_register_i,
    input  wire logic [15:0]       page_descriptor_register_i,
    input  wire logic [15:0]       status_zero_i,
    // Console.
    input  wire logic [1:0]        console_switch_i,
    input  wire logic              console_button_state_i,
    input  wire logic              console_loop_i,
    input  wire logic              periph_page_i,
    // Outputs.
    output logic                   special_instr_detected_n_o,
    output logic                   fetch_recycle_o,
    output logic                   rd_jam_en_o,
    output logic [15:0]            rd_jam_o,
    output logic [15:0]            data_bus_o,
    output logic                   data_bus_en_o,
    output logic                   phys_addr_bit17_o,
    output logic                   phys_addr_bit16_o,
    output logic [17:0]            bus_addr_o,
    output logic                   relocate_o,
    output logic                   inhibit_mode_field_load_n_o,
    output logic                   mode_select_hi_o,
    output logic                   mode_select_lo_o,
    output logic [1:0]             applied_mode_o,
    output mih_pkg::mih_hook_t     hook_o,
    output mih_pkg::mih_lamps_t    lamps_o
);
    import mih_pkg::*;

    // ------------------------------------------------------------
    // Fetch sequencing state
    // ------------------------------------------------------------

    typedef enum logic [0:0]
    {
        MIH_IDLE    = 1'b0,
        MIH_REFETCH = 1'b1
    } mih_state_t;

    mih_state_t  state_q;
    mih_state_t  state_d;
    logic        ir_clk_q;
    logic        mfp_q;
    logic        mfp_d;
    logic        mtp_q;
    logic        mtp_d;
    logic [5:0]  operand_q;
    logic [5:0]  operand_d;
    logic [15:0] capture_q;
    logic [1:0]  sw_meta_q;
    logic [1:0]  sw_sync_q;
    logic        btn_meta_q;
    logic        btn_sync_q;
    logic [1:0]  ext_q;

    // Mode field decoding used by several consumers.
    function automatic logic [1:0] mode_field(input logic [15:0] processor_status_word, input logic prev);
        mode_field = prev ? processor_status_word[PRV_HI:PRV_LO] : processor_status_word[CUR_HI:CUR_LO];
    endfunction

    // ------------------------------------------------------------
    // Combinational decode
    // ------------------------------------------------------------

    wire logic       ir_fall     = ir_clk_q & ~instr_reg_clock_i;
    wire logic [8:0] opc_field   = instruction_register_i[OPC_HI:OPC_LO];
    wire logic       is_mfp      = (opc_field == MFP_OPC);
    wire logic       is_mtp      = (opc_field == MTP_OPC);
    wire logic [1:0] cur_mode    = mode_field(processor_status_word_i, 1'b0);
    wire logic [1:0] prv_mode    = mode_field(processor_status_word_i, 1'b1);
    wire logic       cur_user    = (cur_mode == MODE_USER);
    wire logic       prv_user    = (prv_mode == MODE_USER);
    wire logic       user_reset  = ~privileged_instr_n_i & processor_status_word_i[CUR_HI]
                                 & (instruction_register_i == RESET_OPC);
    wire logic       special     = is_mfp | is_mtp | user_reset;
    wire logic       start_hook  = ir_fall & (state_q == MIH_IDLE) & special;
    wire logic [5:0] new_opd     = instruction_register_i[OPD_HI:0];
    wire logic       abort       = |fault_flags_i;

    // Substituted word: move with the stack side filled in.
    wire logic [15:0] jam_mfp    = {MOV_OPC, new_opd, PUSH_SP_FLD};
    wire logic [15:0] jam_mtp    = {MOV_OPC, POP_SP_FLD, new_opd};
    wire logic [15:0] jam_word   = user_reset ? NOP_OPC
                                 : (is_mfp ? jam_mfp : jam_mtp);

    // Next state: the substituted word is loaded on the next fall.
    always_comb
    begin
        state_d   = state_q;
        mfp_d     = mfp_q;
        mtp_d     = mtp_q;
        operand_d = operand_q;
        unique case (state_q)
            MIH_IDLE:
            begin
                if (ir_fall)
                begin
                    mfp_d     = is_mfp & ~user_reset;
                    mtp_d     = is_mtp & ~user_reset;
                    operand_d = new_opd;
                    if (special)
                    begin
                        state_d = MIH_REFETCH;
                    end
                end
            end
            MIH_REFETCH:
            begin
                if (ir_fall)
                begin
                    state_d = MIH_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Stack hooks
    // ------------------------------------------------------------

    wire logic src_m0    = (operand_q[OPD_HI:MODE_LO] == MODE_ZERO);
    wire logic sp_reg    = (operand_q[REG_HI:0] == SP_REG);
    wire logic sp_ref    = sp_reg | user_stack_ref_i;
    wire logic mfp_sm0   = mfp_q & src_m0 & sp_reg;
    wire logic src_hook  = mfp_q & src_m0 & sp_ref & prv_user;
    wire logic dst_hook  = mtp_q & src_m0 & sp_ref & prv_user;

    // ------------------------------------------------------------
    // Mode, relocation and address selection
    // ------------------------------------------------------------

    wire logic       sel_hi     = mode_select_bits_i[1];
    wire logic       sel_lo     = mode_select_bits_i[0];
    wire logic [1:0] mode_sel   = sel_hi ? prv_mode
                                : (sel_lo ? cur_mode : MODE_KERNEL);
    wire logic       relocate   = relocation_gate_bit_i & relocate_enable_i;
    wire logic [1:0] upper      = console_loop_i ? ext_q
                                : {2{periph_page_i}};
    wire logic [17:0] addr_next = relocate ? relocated_addr_i
                                : {upper, vba_i};
    wire logic       inhibit_n  = ~(cur_user & implicit_ps_load_i);
    wire logic       ext_load   = btn_sync_q & console_loop_i;

    // Read source choice: page select with bit 5 set is the base register,
    // otherwise the descriptor; without page select bit 2 picks the capture.
    wire logic [15:0] rd_page   = vba_i[VBA_PAGE] ? page_base_register_i
                                : page_descriptor_register_i;
    wire logic [15:0] rd_stat   = vba_i[VBA_SR] ? capture_q : status_zero_i;
    wire logic [15:0] rd_word   = page_reg_select_i ? rd_page : rd_stat;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Fetch sequencing flags and saved operand field.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q   <= MIH_IDLE;
            ir_clk_q  <= 1'b0;
            mfp_q     <= 1'b0;
            mtp_q     <= 1'b0;
            operand_q <= '0;
        end
        else
        begin
            state_q   <= state_d;
            ir_clk_q  <= instr_reg_clock_i;
            mfp_q     <= mfp_d;
            mtp_q     <= mtp_d;
            operand_q <= operand_d;
        end
    end

    // Detection, recycle pulse and jammed read word.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            special_instr_detected_n_o <= 1'b1;
            fetch_recycle_o            <= 1'b0;
            rd_jam_en_o                <= 1'b0;
            rd_jam_o                   <= WORD_RST;
        end
        else
        begin
            fetch_recycle_o <= start_hook;
            if (start_hook)
            begin
                special_instr_detected_n_o <= 1'b0;
                rd_jam_en_o                <= 1'b1;
                rd_jam_o                   <= jam_word;
            end
            else if (ir_fall)
            begin
                special_instr_detected_n_o <= 1'b1;
                rd_jam_en_o                <= 1'b0;
            end
        end
    end

    // Fetch address capture, frozen while any fault is flagged.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            capture_q <= WORD_RST;
        end
        else if (ir_fall && !abort)
        begin
            capture_q <= vba_i;
        end
    end

    // Two-stage synchronisers for console pins.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sw_meta_q  <= EXT_RST;
            sw_sync_q  <= EXT_RST;
            btn_meta_q <= 1'b0;
            btn_sync_q <= 1'b0;
        end
        else
        begin
            sw_meta_q  <= console_switch_i;
            sw_sync_q  <= sw_meta_q;
            btn_meta_q <= console_button_state_i;
            btn_sync_q <= btn_meta_q;
        end
    end

    // Console extension register.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ext_q <= EXT_RST;
        end
        else if (ext_load)
        begin
            ext_q <= sw_sync_q;
        end
    end

    // Read data mux towards the processor data bus.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            data_bus_o    <= WORD_RST;
            data_bus_en_o <= 1'b0;
        end
        else
        begin
            data_bus_o    <= read_mux_enable_n_i ? WORD_RST : rd_word;
            data_bus_en_o <= ~read_mux_enable_n_i;
        end
    end

    // Address, mode select and relocation outputs.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            phys_addr_bit17_o           <= 1'b0;
            phys_addr_bit16_o           <= 1'b0;
            bus_addr_o                  <= ADDR_RST;
            relocate_o                  <= 1'b0;
            inhibit_mode_field_load_n_o <= 1'b1;
            mode_select_hi_o            <= 1'b0;
            mode_select_lo_o            <= 1'b0;
            applied_mode_o              <= MODE_KERNEL;
        end
        else
        begin
            phys_addr_bit17_o           <= upper[1];
            phys_addr_bit16_o           <= upper[0];
            bus_addr_o                  <= addr_next;
            relocate_o                  <= relocate;
            inhibit_mode_field_load_n_o <= inhibit_n;
            mode_select_hi_o            <= sel_hi;
            mode_select_lo_o            <= sel_lo;
            applied_mode_o              <= mode_sel;
        end
    end

    // Stack hooks and console lamps.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            hook_o  <= '{src_hook: 1'b0, dst_hook: 1'b0, move_from_src_mode0_n: 1'b1};
            lamps_o <= '1;
        end
        else
        begin
            hook_o.src_hook              <= src_hook;
            hook_o.dst_hook              <= dst_hook;
            hook_o.move_from_src_mode0_n <= ~mfp_sm0;
            lamps_o.relocation_on_n       <= ~relocate_enable_i;
            lamps_o.user_mode_lamp_n      <= ~processor_status_word_i[CUR_HI];
            lamps_o.console_addr_lamp17_n <= ~ext_q[1];
            lamps_o.console_addr_lamp16_n <= ~ext_q[0];
        end
    end

endmodule // mih_top

// ==== tb/mih_cpu_model.sv ====
// Behavioural host processor: fetch clock, refetch on hook, peripheral page flag.
`timescale 1ns/1ps

module mih_cpu_model
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        fetch_go_i,
    input  wire logic [15:0] fetch_word_i,
    input  wire logic [15:0] vba_i,
    input  wire logic        detected_n_i,
    input  wire logic        jam_en_i,
    input  wire logic [15:0] jam_i,
    output logic             ir_clock_o,
    output logic [15:0]      ir_word_o,
    output logic             periph_page_o
);
    logic [1:0] ph_q;
    logic [2:0] cnt_q;
    logic       refetched_q;

    // Top three address bits all set select the peripheral page.
    assign periph_page_o = &vba_i[15:13];

    // Fetch sequencer; a hook makes it recycle once and load the jam word.
    always @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ph_q        <= 2'h0;
            cnt_q       <= 3'h0;
            refetched_q <= 1'b0;
            ir_clock_o  <= 1'b0;
            ir_word_o   <= 16'h0000;
        end
        else if (ph_q == 2'h0 && fetch_go_i)
        begin
            ir_word_o   <= fetch_word_i;
            ir_clock_o  <= 1'b1;
            refetched_q <= 1'b0;
            ph_q        <= 2'h1;
        end
        else if (ph_q == 2'h1)
        begin
            ir_clock_o <= 1'b0;
            cnt_q      <= 3'h0;
            ph_q       <= 2'h2;
        end
        else if (ph_q == 2'h2 && !detected_n_i && jam_en_i && !refetched_q)
        begin
            ir_word_o   <= jam_i;
            ir_clock_o  <= 1'b1;
            refetched_q <= 1'b1;
            ph_q        <= 2'h1;
        end
        else if (ph_q == 2'h2)
        begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h5)
                ph_q <= 2'h0;
        end
    end

endmodule // mih_cpu_model

// ==== tb/mih_monitor.sv ====
// Checker for the instruction hook, upper address and lamp outputs.
`timescale 1ns/1ps

module mih_monitor
(
    input  wire logic                clock_i,
    input  wire logic                rst_n_i,
    input  wire logic                instr_reg_clock_i,
    input  wire logic [15:0]         instruction_register_i,
    input  wire logic [15:0]         processor_status_word_i,
    input  wire logic                privileged_instr_n_i,
    input  wire logic                implicit_ps_load_i,
    input  wire logic                relocation_gate_bit_i,
    input  wire logic                relocate_enable_i,
    input  wire logic [17:0]         relocated_addr_i,
    input  wire logic                console_loop_i,
    input  wire logic                periph_page_i,
    input  wire logic                special_instr_detected_n_o,
    input  wire logic                fetch_recycle_o,
    input  wire logic [15:0]         rd_jam_o,
    input  wire logic                phys_addr_bit17_o,
    input  wire logic                phys_addr_bit16_o,
    input  wire logic [17:0]         bus_addr_o,
    input  wire logic                relocate_o,
    input  wire logic                inhibit_mode_field_load_n_o,
    input  wire mih_pkg::mih_lamps_t lamps_o
);
    import mih_pkg::*;

    logic       irc_q;
    wire        fall_w = irc_q & ~instr_reg_clock_i;
    wire        idle_w = special_instr_detected_n_o;
    wire  [8:0] opc_w  = instruction_register_i[14:6];

    // Last instruction clock level, to find the fetch event.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            irc_q <= 1'b0;
        else
            irc_q <= instr_reg_clock_i;
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_mfp_jam_word: assert property (fall_w && idle_w && opc_w == MFP_OPC
        |=> !idle_w && rd_jam_o == {MOV_OPC, $past(instruction_register_i[5:0]), PUSH_SP_FLD})
        else $error("move-from jam word wrong");
    a_mtp_jam_word: assert property (fall_w && idle_w && opc_w == MTP_OPC
        |=> !idle_w && rd_jam_o == {MOV_OPC, POP_SP_FLD, $past(instruction_register_i[5:0])})
        else $error("move-to jam word wrong");
    a_user_reset_nop: assert property (fall_w && idle_w && instruction_register_i == RESET_OPC
        && !privileged_instr_n_i && processor_status_word_i[15] |=> !idle_w && rd_jam_o == NOP_OPC)
        else $error("user reset not replaced");
    a_kernel_reset_kept: assert property (fall_w && idle_w && instruction_register_i == RESET_OPC
        && !processor_status_word_i[15] |=> idle_w)
        else $error("kernel reset was hooked");
    a_hook_holds: assert property (!idle_w && !fall_w |=> !idle_w)
        else $error("hook ended before refetch");
    a_recycle_pulse: assert property (fetch_recycle_o |=> !fetch_recycle_o && !idle_w)
        else $error("recycle pulse too long");
    a_periph_page: assert property (!console_loop_i
        |=> phys_addr_bit17_o == $past(periph_page_i) && phys_addr_bit16_o == $past(periph_page_i))
        else $error("peripheral page bits wrong");
    a_relocate_on: assert property (relocation_gate_bit_i && relocate_enable_i
        |=> relocate_o && bus_addr_o == $past(relocated_addr_i))
        else $error("relocated address not used");
    a_relocate_off: assert property (!relocation_gate_bit_i |=> !relocate_o)
        else $error("relocation not gated");
    a_mode_inhibit: assert property (1'b1 |=> inhibit_mode_field_load_n_o ==
        !($past(processor_status_word_i[15:14]) == MODE_USER && $past(implicit_ps_load_i)))
        else $error("mode field inhibit wrong");
    a_lamps_follow: assert property (1'b1 |=> lamps_o.user_mode_lamp_n ==
        !$past(processor_status_word_i[15]) && lamps_o.relocation_on_n == !$past(relocate_enable_i))
        else $error("lamp drive wrong");

endmodule // mih_monitor

bind mih_top mih_monitor u_mon (.*);

// ==== tb/tb_mmu_instr_hook_and_vpc_capture.sv ====
// Testbench for the instruction hook and fetch address capture block.
`timescale 1ns/1ps

module tb_mmu_instr_hook_and_vpc_capture;
    import mih_pkg::*;

    logic clock_i, rst_n_i, instr_reg_clock_i, privileged_instr_n_i, implicit_ps_load_i, user_stack_ref_i;
    logic relocation_gate_bit_i, relocate_enable_i, read_mux_enable_n_i, page_reg_select_i, periph_page_i;
    logic console_button_state_i, console_loop_i, fetch_go, special_instr_detected_n_o, fetch_recycle_o;
    logic rd_jam_en_o, data_bus_en_o, phys_addr_bit17_o, phys_addr_bit16_o, relocate_o;
    logic inhibit_mode_field_load_n_o, mode_select_hi_o, mode_select_lo_o;
    logic [1:0]  mode_select_bits_i, console_switch_i, applied_mode_o;
    logic [3:0]  fault_flags_i;
    logic [15:0] instruction_register_i, vba_i, processor_status_word_i, page_base_register_i, fetch_word;
    logic [15:0] page_descriptor_register_i, status_zero_i, rd_jam_o, data_bus_o;
    logic [17:0] relocated_addr_i, bus_addr_o;
    mih_hook_t   hook_o;
    mih_lamps_t  lamps_o;
    int          err_total, checked, cycles;

    mih_top dut (.*);

    mih_cpu_model cpu (.clock_i, .rst_n_i, .fetch_go_i(fetch_go), .fetch_word_i(fetch_word), .vba_i,
        .detected_n_i(special_instr_detected_n_o), .jam_en_i(rd_jam_en_o), .jam_i(rd_jam_o),
        .ir_clock_o(instr_reg_clock_i), .ir_word_o(instruction_register_i), .periph_page_o(periph_page_i));

    // Clock and a cycle ceiling that cuts a hang short.
    always #12.5 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One fetch through the processor model; records any hook it triggers.
    task automatic fetch(input logic [15:0] w, input logic [15:0] processor_status_word, input logic pn, input logic hk,
                         input logic [15:0] jam, input logic [2:0] stk);
        logic        seen = 1'b0;
        logic [15:0] jw = 16'h0000;
        logic [2:0]  hw = 3'h0;
        @(negedge clock_i);
        processor_status_word_i = processor_status_word;
        privileged_instr_n_i = pn;
        fetch_word = w;
        fetch_go = 1'b1;
        @(negedge clock_i);
        fetch_go = 1'b0;
        repeat (30)
        begin
            @(negedge clock_i);
            if (fetch_recycle_o === 1'b1)
            begin
                seen = 1'b1;
                jw = rd_jam_o;
                @(negedge clock_i);
                hw = hook_o;
            end
        end
        chk(seen, hk);
        chk(jw, jam);
        chk(hw, stk);
        chk(special_instr_detected_n_o, 1'b1);
        privileged_instr_n_i = 1'b1;
    endtask

    // Internal register read, then the idle bus value.
    task automatic rd(input logic ps, input logic [15:0] va, input logic [15:0] exp);
        @(negedge clock_i);
        read_mux_enable_n_i = 1'b0;
        page_reg_select_i = ps;
        vba_i = va;
        @(negedge clock_i);
        read_mux_enable_n_i = 1'b1;
        chk({data_bus_en_o, data_bus_o}, {1'b1, exp});
        @(negedge clock_i);
        chk({data_bus_en_o, data_bus_o}, 18'h0);
    endtask

    task automatic mode(input logic [15:0] processor_status_word, input logic [1:0] sel, input logic [3:0] exp);
        @(negedge clock_i);
        processor_status_word_i = processor_status_word;
        mode_select_bits_i = sel;
        repeat (2) @(negedge clock_i);
        chk({inhibit_mode_field_load_n_o, applied_mode_o, lamps_o.user_mode_lamp_n}, exp);
        chk({mode_select_hi_o, mode_select_lo_o}, sel);
    endtask

    // Main sequence.
    initial
    begin
        {clock_i, rst_n_i, fetch_go, implicit_ps_load_i, user_stack_ref_i, relocation_gate_bit_i} = 6'h0;
        {relocate_enable_i, page_reg_select_i, console_button_state_i, console_loop_i} = 4'h0;
        {privileged_instr_n_i, read_mux_enable_n_i} = 2'h3;
        {mode_select_bits_i, console_switch_i, fault_flags_i} = 8'h0;
        {vba_i, processor_status_word_i, fetch_word, relocated_addr_i} = 66'h0;
        page_base_register_i = 16'ha5a5;
        page_descriptor_register_i = 16'h3c3c;
        status_zero_i = 16'h0101;
        repeat (12) @(negedge clock_i);
        rst_n_i = 1'b1;
        fetch({1'b0, MFP_OPC, 6'o06}, 16'h3000, 1'b1, 1'b1, {MOV_OPC, 6'o06, PUSH_SP_FLD}, 3'h4);
        fetch({1'b1, MFP_OPC, 6'o12}, 16'h3000, 1'b1, 1'b1, {MOV_OPC, 6'o12, PUSH_SP_FLD}, 3'h1);
        fetch({1'b0, MTP_OPC, 6'o06}, 16'h3000, 1'b1, 1'b1, {MOV_OPC, POP_SP_FLD, 6'o06}, 3'h3);
        fetch({1'b1, MTP_OPC, 6'o23}, 16'h3000, 1'b1, 1'b1, {MOV_OPC, POP_SP_FLD, 6'o23}, 3'h1);
        fetch(RESET_OPC, 16'hf000, 1'b0, 1'b1, NOP_OPC, 3'h1);
        fetch(RESET_OPC, 16'h0000, 1'b0, 1'b0, 16'h0, 3'h0);
        fetch(16'h15c0, 16'h3000, 1'b1, 1'b0, 16'h0, 3'h0);
        $display("hook test done");
        vba_i = 16'h1234;
        fetch(16'h15c0, 16'h0000, 1'b1, 1'b0, 16'h0, 3'h0);
        rd(1'b0, 16'h0004, 16'h1234);
        for (int i = 0; i < 4; i++)
        begin
            fault_flags_i = 4'h1 << i;
            vba_i = 16'h5670 + 16'(i);
            fetch(16'h15c0, 16'h0000, 1'b1, 1'b0, 16'h0, 3'h0);
            fault_flags_i = 4'h0;
            rd(1'b0, 16'h0004, 16'h1234);
        end
        rd(1'b1, 16'h0020, 16'ha5a5);
        rd(1'b1, 16'h0000, 16'h3c3c);
        rd(1'b0, 16'h0000, 16'h0101);
        $display("capture and read test done");
        console_loop_i = 1'b1;
        console_switch_i = 2'h2;
        console_button_state_i = 1'b1;
        repeat (6) @(negedge clock_i);
        console_button_state_i = 1'b0;
        console_switch_i = 2'h1;
        repeat (6) @(negedge clock_i);
        chk({phys_addr_bit17_o, phys_addr_bit16_o, lamps_o[1:0]}, 4'h9);
        console_loop_i = 1'b0;
        vba_i = 16'he000;
        repeat (2) @(negedge clock_i);
        chk(bus_addr_o, 18'h3e000);
        vba_i = 16'h6000;
        repeat (2) @(negedge clock_i);
        chk(bus_addr_o, 18'h06000);
        $display("console test done");
        {relocation_gate_bit_i, relocate_enable_i, relocated_addr_i} = {2'h3, 18'h2abcd};
        repeat (2) @(negedge clock_i);
        chk({relocate_o, lamps_o.relocation_on_n, bus_addr_o[15:0]}, 18'h2abcd);
        relocate_enable_i = 1'b0;
        repeat (2) @(negedge clock_i);
        chk({relocate_o, lamps_o.relocation_on_n}, 2'h1);
        implicit_ps_load_i = 1'b1;
        mode(16'hc000, 2'h2, 4'h0);
        mode(16'hc000, 2'h1, 4'h6);
        mode(16'h3000, 2'h2, 4'hf);
        $display("relocation and mode test done");
        test_done();
    end

endmodule // tb_mmu_instr_hook_and_vpc_capture
